// *** inc/sepe_pkg.sv ***
// shared constants and types for the serial eeprom protocol engine
package sepe_pkg;
	// system clock and program cycle timing
	localparam int CLK_FREQ_MHZ = 10;
	localparam int PROG_CYCLE_TIME_US = 10000;
	localparam int PROG_CYCLES = PROG_CYCLE_TIME_US * CLK_FREQ_MHZ;
	localparam int PROG_CNT_W = 20;

	// array and page geometry
	localparam int ADDR_W = 15;
	localparam int PAGE_W = 6;
	localparam int MEM_BYTES = 32768;
	localparam int PAGE_BYTES = 64;
	localparam logic [PAGE_W-1:0] PAGE_LAST = 6'h3F;
	localparam logic [ADDR_W-1:0] ADDR_RST = 15'h0000;
	localparam logic [ADDR_W-1:0] ADDR_MASK_FULL = 15'h7FFF;
	localparam logic [ADDR_W-1:0] ADDR_MASK_SMALL = 15'h3FFF;
	localparam logic [7:0] BYTE_RST = 8'h00;

	// device select layout: type code in bits 7..3
	localparam logic [4:0] DEV_TYPE = 5'h14;
	localparam int SEL_HIGH_POS = 2;
	localparam int SEL_LOW_POS = 1;
	localparam int RW_POS = 0;

	// bit counter values at the byte and acknowledge boundaries
	localparam logic [3:0] BIT_ZERO = 4'h0;
	localparam logic [3:0] BIT_ACK = 4'h8;
	localparam logic [3:0] BIT_END = 4'h9;

	// positions of the pins in the synchroniser vector
	localparam int PIN_SCL = 0;
	localparam int PIN_SDA = 1;
	localparam int PIN_WP = 2;
	localparam int PIN_SELH = 3;
	localparam int PIN_SELL = 4;
	localparam int PIN_SMALL = 5;
	localparam int PIN_NUM = 6;

	// byte-level protocol states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_DEVSEL,
		ST_ADDR_HI,
		ST_ADDR_LO,
		ST_WDATA,
		ST_RDATA
	} sepe_state_e;
endpackage

// *** hdl/sepe_prog_timer.sv ***
// self-timed program cycle counter on the system clock
`timescale 1ns/100ps
module sepe_prog_timer #(
	parameter int PROG_CYCLES = sepe_pkg::PROG_CYCLES
) (
	input  wire logic clock,
	input  wire logic rst_n,
	input  wire logic progReq,
	output logic      progDone,
	output logic      busy
);
	import sepe_pkg::*;

	localparam logic [PROG_CNT_W-1:0] CNT_LAST =
		PROG_CNT_W'(PROG_CYCLES - 1);

	logic                  reqMeta;
	logic                  reqSync;
	logic                  reqSeen;
	logic                  reqEvent;
	logic [PROG_CNT_W-1:0] cnt;

	// toggle request from the link domain, two stages then edge
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			reqMeta <= 1'b0;
			reqSync <= 1'b0;
			reqSeen <= 1'b0;
		end else begin
			reqMeta <= progReq;
			reqSync <= reqMeta;
			reqSeen <= reqSync;
		end
	end

	assign reqEvent = reqSync ^ reqSeen;

	// count the program time, answer with a toggle when done
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			busy <= 1'b0;
			cnt <= '0;
			progDone <= 1'b0;
		end else if (reqEvent && !busy) begin
			busy <= 1'b1;
			cnt <= '0;
		end else if (busy) begin
			if (cnt == CNT_LAST) begin
				busy <= 1'b0;
				progDone <= ~progDone;
			end else begin
				cnt <= cnt + 1'b1;
			end
		end
	end
endmodule

// *** hdl/sepe_engine.sv ***
// two-wire serial eeprom command engine with array and page latch
`timescale 1ns/100ps
// Contract
// - select byte follows every start; top five bits must be 10100.
// - two select bits compared against the two strapped select pins.
// - a floating select strap reads as logic low.
// - last select bit chooses read (one) or write (zero).
// - matching select acknowledged low; mismatch releases bus until start.
// - write protect high blocks programming of the whole array.
// - byte write is select, two address bytes, one data byte, acked.
// - stop starts program cycle; bus ignored until it finishes.
// - page write takes up to 64 bytes, each acknowledged low.
// - after each data byte only low six address bits increment.
// - more than 64 bytes wrap in the page and overwrite.
// - select during programming not acked; acked once programming done.
// - address counter holds last address plus one between operations.
// - read counter wraps from array end to address zero.
// - current read shifts out byte at counter after read select.
// - controller ack advances sequential read; nack and stop end it.
// - bytes are eight bits; device drives low on ninth clock.
// - sda fall with scl high is start, rise is stop.
module sepe_engine #(
	parameter int PROG_CYCLES = sepe_pkg::PROG_CYCLES
) (
	input  wire logic clock,
	input  wire logic rst_n,
	input  wire logic linkClock,
	input  wire logic scl,
	input  wire logic sdaIn,
	output logic      sdaOut,
	output logic      sdaOe,
	input  wire logic writeProtect,
	input  wire logic selectPinHigh,
	input  wire logic selectPinLow,
	input  wire logic smallCapacity,
	output logic      programBusy
);
	import sepe_pkg::*;

	// link domain reset release
	logic                linkRstMeta;
	logic                linkRst_n;

	// pin synchronisers and bus events
	logic [PIN_NUM-1:0]  pinRaw;
	logic [PIN_NUM-1:0]  pinMeta;
	logic [PIN_NUM-1:0]  pinSync;
	logic                sclNow;
	logic                sdaNow;
	logic                sclPrev;
	logic                sdaPrev;
	logic                sclRise;
	logic                sclFall;
	logic                startCond;
	logic                stopCond;

	// byte engine
	sepe_state_e         state;
	logic [3:0]          bitCnt;
	logic [7:0]          rxShift;
	logic [7:0]          txShift;
	logic                masterNack;
	logic                byteDone;
	logic                ackDone;
	logic                devMatch;
	logic                selAck;
	logic                wrByte;
	logic                loadRead;
	logic                midBit;

	// addressing
	logic [7:0]          addrHi;
	logic [ADDR_W-1:0]   addrCounter;
	logic [ADDR_W-1:0]   addrMask;
	logic [ADDR_W-1:0]   loadAddr;

	// page latch, array and program handshake
	logic [7:0]          pageBuf [PAGE_BYTES];
	logic [PAGE_BYTES-1:0] pageMask;
	logic [7:0]          mem [MEM_BYTES];
	logic                busy;
	logic                progStart;
	logic                progReq;
	logic                progDone;
	logic                doneMeta;
	logic                doneSync;
	logic                doneSeen;
	logic                doneEvent;
	logic                committing;
	logic [PAGE_W-1:0]   commitIdx;
	logic                commitEnd;

	// open drain: the pad only ever pulls low
	assign sdaOut = 1'b0;

	// async assert, release synchronised to the link clock
	always_ff @(posedge linkClock or negedge rst_n) begin
		if (!rst_n) begin
			linkRstMeta <= 1'b0;
			linkRst_n <= 1'b0;
		end else begin
			linkRstMeta <= 1'b1;
			linkRst_n <= linkRstMeta;
		end
	end

	// straps read low
	// pad bias pulls an open strap low before it reaches this vector
	assign pinRaw[PIN_SCL] = scl;
	assign pinRaw[PIN_SDA] = sdaIn;
	assign pinRaw[PIN_WP] = writeProtect;
	assign pinRaw[PIN_SELH] = selectPinHigh;
	assign pinRaw[PIN_SELL] = selectPinLow;
	assign pinRaw[PIN_SMALL] = smallCapacity;

	// two flops per pin; only the second stage is read by logic
	for (genvar g = 0; g < PIN_NUM; g++) begin : gSync
		always_ff @(posedge linkClock or negedge linkRst_n) begin
			if (!linkRst_n) begin
				pinMeta[g] <= 1'b1;
				pinSync[g] <= 1'b1;
			end else begin
				pinMeta[g] <= pinRaw[g];
				pinSync[g] <= pinMeta[g];
			end
		end
	end

	assign sclNow = pinSync[PIN_SCL];
	assign sdaNow = pinSync[PIN_SDA];

	// previous bus levels for edge detection
	always_ff @(posedge linkClock or negedge linkRst_n) begin
		if (!linkRst_n) begin
			sclPrev <= 1'b1;
			sdaPrev <= 1'b1;
		end else begin
			sclPrev <= sclNow;
			sdaPrev <= sdaNow;
		end
	end

	// start and stop
	// sda moving while scl stays high marks the frame edges
	assign sclRise = sclNow & ~sclPrev;
	assign sclFall = ~sclNow & sclPrev;
	assign startCond = sclNow & sclPrev & sdaPrev & ~sdaNow;
	assign stopCond = sclNow & sclPrev & ~sdaPrev & sdaNow;

	// byte and acknowledge boundaries, seen on the scl fall
	assign byteDone = sclFall && (bitCnt == BIT_ACK);
	assign ackDone = sclFall && (bitCnt == BIT_END);
	assign midBit = sclFall && (bitCnt != BIT_ZERO)
		&& (bitCnt < BIT_ACK);

	assign devMatch = (rxShift[7:3] == DEV_TYPE)
		&& (rxShift[SEL_HIGH_POS] == pinSync[PIN_SELH])
		&& (rxShift[SEL_LOW_POS] == pinSync[PIN_SELL]);

	// no ack while busy
	// a poll during programming falls through to idle unanswered
	assign selAck = (state == ST_DEVSEL) && devMatch && !busy;

	assign wrByte = byteDone && (state == ST_WDATA);
	assign loadRead = ackDone && (state == ST_RDATA) && !masterNack;

	assign addrMask = pinSync[PIN_SMALL] ? ADDR_MASK_SMALL
		: ADDR_MASK_FULL;
	assign loadAddr = {addrHi[6:0], rxShift} & addrMask;

	// stop launches write
	// only a stop straight after acked data bytes programs
	assign progStart = stopCond && (state == ST_WDATA)
		&& (|pageMask) && !busy;

	// bit counter: eight data clocks then the acknowledge clock
	always_ff @(posedge linkClock or negedge linkRst_n) begin
		if (!linkRst_n) begin
			bitCnt <= BIT_ZERO;
		end else if (startCond || stopCond) begin
			bitCnt <= BIT_ZERO;
		end else if (ackDone) begin
			bitCnt <= BIT_ZERO;
		end else if (sclRise && (bitCnt != BIT_END)) begin
			bitCnt <= bitCnt + 1'b1;
		end
	end

	always_ff @(posedge linkClock or negedge linkRst_n) begin
		if (!linkRst_n) begin
			rxShift <= BYTE_RST;
		end else if (sclRise && (bitCnt < BIT_ACK)) begin
			rxShift <= {rxShift[6:0], sdaNow};
		end
	end

	// controller ack sample
	// taken on the ninth rise; our own ack after select reads as 0
	always_ff @(posedge linkClock or negedge linkRst_n) begin
		if (!linkRst_n) begin
			masterNack <= 1'b0;
		end else if (sclRise && (bitCnt == BIT_ACK)
			&& (state == ST_RDATA)) begin
			masterNack <= sdaNow;
		end
	end

	// byte-level sequencing; a start always reopens select so polls work
	always_ff @(posedge linkClock or negedge linkRst_n) begin
		if (!linkRst_n) begin
			state <= ST_IDLE;
		end else if (startCond) begin
			state <= ST_DEVSEL;
		end else if (stopCond) begin
			state <= ST_IDLE;
		end else if (byteDone) begin
			case (state)
				ST_DEVSEL: begin
					if (!selAck)
						state <= ST_IDLE;
					else if (rxShift[RW_POS])
						state <= ST_RDATA;
					else
						state <= ST_ADDR_HI;
				end
				ST_ADDR_HI: state <= ST_ADDR_LO;
				ST_ADDR_LO: state <= ST_WDATA;
				ST_WDATA:   state <= ST_WDATA;
				ST_RDATA:   state <= ST_RDATA;
				default:    state <= ST_IDLE;
			endcase
		end else if (ackDone && (state == ST_RDATA) && masterNack) begin
			state <= ST_IDLE;
		end
	end

	// outgoing byte: loaded at the end of an ack clock, shifted per bit
	always_ff @(posedge linkClock or negedge linkRst_n) begin
		if (!linkRst_n) begin
			txShift <= BYTE_RST;
		end else if (loadRead) begin
			txShift <= mem[addrCounter];
		end else if (midBit && (state == ST_RDATA)) begin
			txShift <= {txShift[6:0], 1'b0};
		end
	end

	// sda pull-down enable; changes after an scl fall, or clears on a start or stop
	always_ff @(posedge linkClock or negedge linkRst_n) begin
		if (!linkRst_n) begin
			sdaOe <= 1'b0;
		end else if (startCond || stopCond) begin
			sdaOe <= 1'b0;
		end else if (byteDone) begin
			case (state)
				ST_DEVSEL:  sdaOe <= selAck;
				ST_ADDR_HI: sdaOe <= 1'b1;
				ST_ADDR_LO: sdaOe <= 1'b1;
				ST_WDATA:   sdaOe <= 1'b1;
				default:    sdaOe <= 1'b0;
			endcase
		end else if (loadRead) begin
			sdaOe <= ~mem[addrCounter][7];
		end else if (ackDone) begin
			sdaOe <= 1'b0;
		end else if (midBit && (state == ST_RDATA)) begin
			sdaOe <= ~txShift[6];
		end
	end

	// address counter
	// survives between frames; only reset clears it
	always_ff @(posedge linkClock or negedge linkRst_n) begin
		if (!linkRst_n) begin
			addrHi <= BYTE_RST;
			addrCounter <= ADDR_RST;
		end else if (byteDone && (state == ST_ADDR_HI)) begin
			addrHi <= rxShift;
		end else if (byteDone && (state == ST_ADDR_LO)) begin
			addrCounter <= loadAddr;
		end else if (wrByte) begin
			addrCounter[PAGE_W-1:0] <= addrCounter[PAGE_W-1:0] + 1'b1;
		end else if (loadRead) begin
			addrCounter <= (addrCounter + 1'b1) & addrMask;
		end
	end

	// page latch data; no reset, the mask says what is valid
	always_ff @(posedge linkClock) begin
		if (wrByte && !pinSync[PIN_WP])
			pageBuf[addrCounter[PAGE_W-1:0]] <= rxShift;
	end

	// byte-valid mask; a wrapped byte simply overwrites its slot
	always_ff @(posedge linkClock or negedge linkRst_n) begin
		if (!linkRst_n) begin
			pageMask <= '0;
		end else if (commitEnd) begin
			pageMask <= '0;
		end else if (byteDone && (state == ST_ADDR_LO)) begin
			pageMask <= '0;
		end else if (wrByte && !pinSync[PIN_WP]) begin
			pageMask[addrCounter[PAGE_W-1:0]] <= 1'b1;
		end
	end

	// program done toggle from the system domain
	always_ff @(posedge linkClock or negedge linkRst_n) begin
		if (!linkRst_n) begin
			doneMeta <= 1'b0;
			doneSync <= 1'b0;
			doneSeen <= 1'b0;
		end else begin
			doneMeta <= progDone;
			doneSync <= doneMeta;
			doneSeen <= doneSync;
		end
	end

	assign doneEvent = doneSync ^ doneSeen;
	assign commitEnd = committing && (commitIdx == PAGE_LAST);

	// busy holds off the bus
	// busy spans the timer and the 64-cycle copy into the array
	always_ff @(posedge linkClock or negedge linkRst_n) begin
		if (!linkRst_n) begin
			busy <= 1'b0;
			progReq <= 1'b0;
			committing <= 1'b0;
			commitIdx <= '0;
		end else if (progStart) begin
			busy <= 1'b1;
			progReq <= ~progReq;
		end else if (doneEvent) begin
			committing <= 1'b1;
			commitIdx <= '0;
		end else if (committing) begin
			commitIdx <= commitIdx + 1'b1;
			if (commitEnd) begin
				committing <= 1'b0;
				busy <= 1'b0;
			end
		end
	end

	// array update one slot per cycle; row is still in the counter
	always_ff @(posedge linkClock) begin
		if (committing && pageMask[commitIdx])
			mem[{addrCounter[ADDR_W-1:PAGE_W], commitIdx}] <=
				pageBuf[commitIdx];
	end

	// self-timed program delay runs on the system clock
	sepe_prog_timer #(
		.PROG_CYCLES(PROG_CYCLES)
	) uTimer (
		.clock    (clock),
		.rst_n    (rst_n),
		.progReq  (progReq),
		.progDone (progDone),
		.busy     (programBusy)
	);
endmodule

// *** tb/sepe_engine_monitor.sv ***
// port checker for the eeprom engine
`timescale 1ns/100ps
module sepe_engine_monitor #(
	parameter int PROG_CYCLES = 20
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic linkClock,
	input wire logic scl,
	input wire logic sdaIn,
	input wire logic sdaOut,
	input wire logic sdaOe,
	input wire logic writeProtect,
	input wire logic selectPinHigh,
	input wire logic selectPinLow,
	input wire logic smallCapacity,
	input wire logic programBusy
);
	int busyCnt;

	// clocks spent busy; cleared whenever idle
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			busyCnt <= 0;
		else if (programBusy)
			busyCnt <= busyCnt + 1;
		else
			busyCnt <= 0;
	end

	property p_open_drain;
		@(posedge linkClock) disable iff (!rst_n) sdaOut == 1'b0;
	endproperty
	a_open_drain: assert property (p_open_drain)
		else $error("data pin driven high");

	// sync delay allows 3 to 5 edges after the clock fall
	property p_edge_timing;
		@(posedge linkClock) disable iff (!rst_n) $changed(sdaOe) |->
			!scl && ($past(scl, 3) || $past(scl, 4) || $past(scl, 5));
	endproperty
	a_edge_timing: assert property (p_edge_timing)
		else $error("data drive changed outside clock low");

	property p_ack_hold;
		@(posedge linkClock) disable iff (!rst_n) $rose(sdaOe) |-> sdaOe[*8];
	endproperty
	a_ack_hold: assert property (p_ack_hold)
		else $error("drive pulse too short");

	property p_busy_len;
		@(posedge clock) disable iff (!rst_n) $fell(programBusy) |->
			busyCnt >= PROG_CYCLES - 1 && busyCnt <= PROG_CYCLES + 1;
	endproperty
	a_busy_len: assert property (p_busy_len)
		else $error("program time wrong");

	property p_protect;
		@(posedge clock) disable iff (!rst_n)
			$rose(programBusy) |-> !writeProtect;
	endproperty
	a_protect: assert property (p_protect)
		else $error("programming while protected");

	property p_quiet;
		@(posedge linkClock) disable iff (!rst_n) programBusy |-> !sdaOe;
	endproperty
	a_quiet: assert property (p_quiet)
		else $error("answer during programming");

	property p_launch;
		@(posedge clock) disable iff (!rst_n)
			$rose(programBusy) |-> scl && sdaIn;
	endproperty
	a_launch: assert property (p_launch)
		else $error("program start without stop");

	// a long clock high is idle or start/stop: never driven
	property p_idle;
		@(posedge linkClock) disable iff (!rst_n) scl[*8] |-> !sdaOe;
	endproperty
	a_idle: assert property (p_idle)
		else $error("drive while bus idle");

	c_prog: cover property (@(posedge clock) $rose(programBusy));
	c_done: cover property (@(posedge clock) $fell(programBusy));
	c_ack: cover property (@(posedge linkClock) $rose(sdaOe));
endmodule

bind sepe_engine sepe_engine_monitor #(.PROG_CYCLES(PROG_CYCLES)) mon_u (
	.clock, .rst_n, .linkClock, .scl, .sdaIn, .sdaOut, .sdaOe,
	.writeProtect, .selectPinHigh, .selectPinLow, .smallCapacity,
	.programBusy);

// *** tb/sepe_bus_model.sv ***
// two-wire bus controller model driving the engine pins
`timescale 1ns/100ps
module sepe_bus_model (
	input  wire logic linkClock,
	input  wire logic sdaOe,
	output logic      scl,
	output wire logic sdaIn
);
	logic pullLow;

	// open drain data line with pull-up
	assign sdaIn = !(pullLow || sdaOe);

	initial begin
		scl = 1'b1;
		pullLow = 1'b0;
	end

	// each clock phase spans six link edges, above the minimum four
	task automatic half();
		repeat (6) @(posedge linkClock);
	endtask

	// start, data falls with clock high
	task automatic startC();
		@(posedge linkClock);
		pullLow <= 1'b0;
		half();
		scl <= 1'b1;
		half();
		pullLow <= 1'b1;
		half();
		scl <= 1'b0;
	endtask

	task automatic stopC();
		@(posedge linkClock);
		pullLow <= 1'b1;
		half();
		scl <= 1'b1;
		half();
		pullLow <= 1'b0;
		half();
	endtask

	// data moves one edge after the clock fall, never with it
	task automatic bitX(input logic b, output logic s);
		@(posedge linkClock);
		pullLow <= !b;
		half();
		scl <= 1'b1;
		half();
		s = sdaIn;
		scl <= 1'b0;
	endtask

	// msb first, ninth clock carries ack
	task automatic xfer(input logic [7:0] d, input logic ackBit,
		output logic [7:0] q, output logic ackSeen);
		for (int i = 7; i >= 0; i--)
			bitX(d[i], q[i]);
		bitX(ackBit, ackSeen);
	endtask
endmodule

// *** tb/testbench.sv ***
// self-checking bench for the eeprom engine
`timescale 1ns/100ps
module testbench;
	import sepe_pkg::*;
	localparam int LIMIT = 20000;
	logic clock, linkClock, rst_n;
	logic writeProtect, selectPinHigh, selectPinLow, smallCapacity;
	wire  scl, sdaIn, sdaOut, sdaOe, programBusy;
	int   errorCnt, cmpCount, cyc;

	sepe_engine #(.PROG_CYCLES(20)) dut_u (.clock, .rst_n, .linkClock,
		.scl, .sdaIn, .sdaOut, .sdaOe, .writeProtect, .selectPinHigh,
		.selectPinLow, .smallCapacity, .programBusy);
	sepe_bus_model m (.linkClock, .sdaOe, .scl, .sdaIn);

	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	// link clock offset so the domains never line up
	initial begin
		linkClock = 1'b0;
		#3;
		forever #7.5 linkClock = ~linkClock;
	end

	task automatic stopTest();
		$display("checks %0d errors %0d", cmpCount, errorCnt);
		if (errorCnt == 0 && cmpCount > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// hang guard
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			errorCnt++;
			stopTest();
		end
	end

	task automatic chk(string n, logic [7:0] e, logic [7:0] g);
		cmpCount++;
		if (g !== e) begin
			errorCnt++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chkA(string n, logic e, logic g);
		cmpCount++;
		if (g !== e) begin
			errorCnt++;
			$display("unexpected %s expected %b seen %b", n, e, g);
		end
	endtask

	// page 5 holds 0x42 plus slot after the wrapped page write
	// address zero and the array end are written before any read so the wrap read never sees unknowns
	function automatic logic [8:0] expv(input logic [15:0] ad);
		logic [14:0] a;
		a = ad[14:0] & (smallCapacity ? ADDR_MASK_SMALL : ADDR_MASK_FULL);
		if (a == 15'h0000)
			return {1'b1, 8'hC3};
		if (a == 15'h7FFF)
			return {1'b1, 8'h5A};
		if (a[14:6] != 9'h005)
			return 9'h000;
		return {1'b1, 8'h42 + {2'h0, a[5:0]}};
	endfunction

	task automatic sendSel(input logic rw, input logic e);
		logic [7:0] q;
		logic       a;
		m.startC();
		m.xfer({DEV_TYPE, 2'b10, rw}, 1'b1, q, a);
		chkA("select ack", e, a);
	endtask
	task automatic sendByte(input logic [7:0] d);
		logic [7:0] q;
		logic       a;
		m.xfer(d, 1'b1, q, a);
		chkA("byte ack", 1'b0, a);
	endtask
	task automatic setAddr(input logic [15:0] ad);
		sendSel(1'b0, 1'b0);
		sendByte(ad[15:8]);
		sendByte(ad[7:0]);
	endtask

	task automatic writeRun(input logic [15:0] ad, input int n,
		input logic [7:0] d0);
		setAddr(ad);
		for (int i = 0; i < n; i++)
			sendByte(d0 + 8'(i));
		m.stopC();
	endtask

	// busy must show, then polls are refused until the copy ends
	task automatic waitProg();
		int         p;
		logic [7:0] q;
		logic       a;
		p = 0;
		while (busy() !== 1'b1 && p < 50) begin
			@(negedge clock);
			p++;
		end
		chkA("busy", 1'b1, busy());
		p = 0;
		a = 1'b1;
		while (a !== 1'b0 && p < 100) begin
			m.startC();
			m.xfer({DEV_TYPE, 3'b100}, 1'b1, q, a);
			if (p == 0)
				chkA("first poll", 1'b1, a);
			p++;
		end
		chkA("poll ack", 1'b0, a);
		m.stopC();
	endtask
	function automatic logic busy();
		return programBusy;
	endfunction

	// dummy write then repeated start read; with cur set, a current read from the counter with no dummy write
	task automatic readRun(input logic [15:0] ad, input int n,
		input logic cur);
		logic [7:0] q;
		logic       a;
		logic [8:0] ev;
		if (!cur)
			setAddr(ad);
		sendSel(1'b1, 1'b0);
		for (int i = 0; i < n; i++) begin
			m.xfer(8'hFF, i == n - 1, q, a);
			ev = expv(ad + 16'(i));
			if (ev[8])
				chk("read data", ev[7:0], q);
		end
		m.stopC();
	endtask

	task automatic protectRun();
		@(posedge clock);
		writeProtect <= 1'b1;
		writeRun(16'h0140, 1, 8'h00);
		repeat (30) @(negedge clock);
		chkA("busy", 1'b0, busy());
		@(posedge clock);
		writeProtect <= 1'b0;
		readRun(16'h0140, 1, 1'b0);
	endtask

	task automatic mismatchRun();
		logic [7:0] bad [4] = '{8'hA0, 8'hA6, 8'hB4, 8'h24};
		logic [7:0] q;
		logic       a;
		foreach (bad[i]) begin
			m.startC();
			m.xfer(bad[i], 1'b1, q, a);
			chkA("bad select", 1'b1, a);
			m.xfer(8'h00, 1'b1, q, a);
			chkA("after bad", 1'b1, a);
			m.stopC();
		end
	endtask

	initial begin
		rst_n = 1'b0;
		writeProtect = 1'b0;
		selectPinHigh = 1'b1;
		selectPinLow = 1'b0;
		smallCapacity = 1'b0;
		repeat (20) @(posedge clock);
		rst_n <= 1'b1;
		repeat (10) @(posedge linkClock);
		writeRun(16'h8000, 1, 8'hC3);
		waitProg();
		writeRun(16'h017E, 66, 8'h40);
		waitProg();
		writeRun(16'h7FFF, 1, 8'h5A);
		waitProg();
		readRun(16'h0140, 63, 1'b0);
		readRun(16'h017F, 1, 1'b1);
		readRun(16'h7FFF, 2, 1'b0);
		@(posedge clock);
		smallCapacity <= 1'b1;
		readRun(16'h4000, 1, 1'b0);
		@(posedge clock);
		smallCapacity <= 1'b0;
		protectRun();
		mismatchRun();
		stopTest();
	end
endmodule
